/* File: fesc_pkg.sv */
// Package of command codes, field positions, timing counts and enumerations for the flash command sequencer.
package fesc_pkg;
  // ==========================================================================
  // Command codes and parameter layout
  // ==========================================================================
  localparam logic [7:0]  CMD_ERASE_SECTOR = 8'h0A;
  localparam logic [7:0]  CMD_UNSECURE     = 8'h0B;
  localparam logic [7:0]  CMD_BACKDOOR_KEY = 8'h0C;
  localparam logic [7:0]  CMD_USER_MARGIN  = 8'h0D;
  localparam int          CMD_HI           = 15;
  localparam int          CMD_LO           = 8;
  localparam int          ADDR_HI_HI       = 7;
  localparam logic [2:0]  IDX_SECTOR       = 3'h1;
  localparam logic [2:0]  IDX_UNSECURE     = 3'h0;
  localparam logic [2:0]  IDX_KEY          = 3'h4;
  localparam logic [2:0]  IDX_MARGIN       = 3'h2;
  localparam logic [1:0]  KEY_ENABLED      = 2'h2;
  localparam logic [15:0] MARGIN_NORMAL    = 16'h0000;
  localparam logic [15:0] MARGIN_ERASED    = 16'h0001;
  localparam logic [15:0] MARGIN_PROGRAM   = 16'h0002;
  localparam logic [1:0]  LEVEL_NORMAL     = 2'h0;
  localparam logic [1:0]  LEVEL_ERASED     = 2'h1;
  localparam logic [1:0]  LEVEL_PROGRAM    = 2'h2;
  localparam logic [2:0]  PHRASE_ZERO      = 3'h0;
  localparam int          NUM_WORDS        = 5;
  localparam int          NUM_KEYS         = 4;
  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int          CLK_MHZ          = 200;
  localparam int          ERASE_TIME_US    = 20;
  localparam int          ERASE_CYCLES     = ERASE_TIME_US * CLK_MHZ;
  localparam int          VERIFY_CYCLES    = 16;
  localparam int          CNT_W            = 16;
  // ==========================================================================
  // Sequencer states
  // ==========================================================================
  typedef enum logic [2:0] {
    FESC_IDLE,
    FESC_ERASE,
    FESC_VERIFY,
    FESC_COMPARE,
    FESC_DONE
  } fesc_state_t;
endpackage

/* File: fesc_sequencer.sv */
// Command sequencer for sector erase, unsecure, backdoor key verify and user margin commands.
`timescale 1ns/1ps
// Function
// - Sector erase code 0x0A, address 23:16 in word 0 low byte, 15:0 in word 1.
// - Sector erase launch erases, verifies, then sets command complete.
// - Sector erase flags access error unless param index is 001.
// - Sector erase flags access error on invalid program-flash address.
// - Sector erase flags access error if address bits 2:0 are nonzero.
// - Protected sector sets protect violation and nothing is erased.
// - Command not permitted in current mode sets access error.
// - Verify error sets first flag; non-correctable error also sets second flag.
// - Unsecure code 0x0B flags access error unless param index is 000.
// - Unsecure erases all flash and EEPROM, releases security on verify pass.
// - Unsecure verify failure sets first verify flag, security unchanged.
// - Unsecure with any protected region sets protect violation.
// - Key command code 0x0C, four keys, access error unless index is 100.
// - Key command runs only if key enable equals 10, else access error.
// - Keys compared in order with stored key; all match releases security.
// - Key mismatch keeps security, access error, blocks key command until reset.
// - Margin command code 0x0D applies margin level to addressed block.
// - Margin 0 normal, 1 toward erased, 2 toward programmed.
// - Margin command flags access error unless param index is 010.
// - Margin setting outside defined encodings sets access error.
module fesc_sequencer #(
  parameter int ERASE_CYCLES_P = fesc_pkg::ERASE_CYCLES,
  parameter int FLASH_TOP_P    = 24'h01_FFFF,
  parameter int FLASH_BASE_P   = 24'h00_0000
) (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        launch,
  input  wire logic [15:0] command_param_word_0,
  input  wire logic [15:0] command_param_word_1,
  input  wire logic [15:0] command_param_word_2,
  input  wire logic [15:0] command_param_word_3,
  input  wire logic [15:0] command_param_word_4,
  input  wire logic [2:0]  param_index,
  input  wire logic        clear_errors,
  input  wire logic        cmd_permitted,
  input  wire logic        sector_protected,
  input  wire logic        any_protected,
  input  wire logic        secured_in,
  input  wire logic [1:0]  backdoor_key_enable,
  input  wire logic [63:0] stored_key,
  input  wire logic        verify_error,
  input  wire logic        verify_fatal,
  output logic             command_complete_flag,
  output logic             access_error_flag,
  output logic             protect_violation_flag,
  output logic             verify_error_flag,
  output logic             verify_fatal_error_flag,
  output logic             secure_release,
  output logic             erase_sector_act,
  output logic             erase_all_act,
  output logic [23:0]      erase_addr,
  output logic [1:0]       margin_level,
  output logic             margin_block_eeprom
);
  // ==========================================================================
  // State
  // ==========================================================================
  fesc_pkg::fesc_state_t state_r, state_nxt;
  logic        command_complete_flag_r, command_complete_flag_nxt;
  logic        access_error_flag_r, access_error_flag_nxt;
  logic        protect_violation_flag_r, protect_violation_flag_nxt;
  logic        mg1_r, mg1_nxt;
  logic        mg0_r, mg0_nxt;
  logic        release_r, release_nxt;
  logic        key_lock_r, key_lock_nxt;
  logic        all_r, all_nxt;
  logic [23:0] addr_r, addr_nxt;
  logic [1:0]  margin_r, margin_nxt;
  logic        mblk_r, mblk_nxt;
  logic [fesc_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
  logic [1:0]  key_i_r, key_i_nxt;
  logic        sec_act_r, sec_act_nxt, all_act_r, all_act_nxt;
  logic [fesc_pkg::CNT_W-1:0] erase_len_r, erase_len_nxt;
  logic [7:0]  code;
  logic [23:0] gaddr;
  logic        addr_ok;
  logic [15:0] key_word;
  logic [15:0] key_ref;

  assign code  = command_param_word_0[fesc_pkg::CMD_HI:fesc_pkg::CMD_LO];
  assign gaddr = {command_param_word_0[fesc_pkg::ADDR_HI_HI:0], command_param_word_1};
  assign addr_ok = (gaddr >= FLASH_BASE_P[23:0]) && (gaddr <= FLASH_TOP_P[23:0]);
  always_comb begin
    unique case (key_i_r)
      2'h0: key_word = command_param_word_1;
      2'h1: key_word = command_param_word_2;
      2'h2: key_word = command_param_word_3;
      default: key_word = command_param_word_4;
    endcase
    key_ref = stored_key[{key_i_r, 4'h0} +: 16];
  end

  // ==========================================================================
  // Sequencer
  // ==========================================================================
  always_comb begin
    state_nxt   = state_r;
    command_complete_flag_nxt    = command_complete_flag_r;
    access_error_flag_nxt  = access_error_flag_r;
    protect_violation_flag_nxt  = protect_violation_flag_r;
    mg1_nxt     = mg1_r;
    mg0_nxt     = mg0_r;
    release_nxt = release_r;
    key_lock_nxt = key_lock_r;
    all_nxt     = all_r;
    addr_nxt    = addr_r;
    margin_nxt  = margin_r;
    mblk_nxt    = mblk_r;
    cnt_nxt     = cnt_r;
    key_i_nxt   = key_i_r;
    unique case (state_r)
      fesc_pkg::FESC_IDLE: begin
        if (clear_errors) begin
          access_error_flag_nxt = 1'b0;
          protect_violation_flag_nxt = 1'b0;
        end
        // Launch is ignored while access error or protect violation flags are pending, as software must clear them first.
        if (launch && command_complete_flag_r && !access_error_flag_r && !protect_violation_flag_r) begin
          command_complete_flag_nxt  = 1'b0;
          mg1_nxt   = 1'b0;
          mg0_nxt   = 1'b0;
          state_nxt = fesc_pkg::FESC_DONE;
          cnt_nxt   = '0;
          key_i_nxt = 2'h0;
          if (!cmd_permitted) begin
            access_error_flag_nxt = 1'b1;
          end else begin
            unique case (code)
              fesc_pkg::CMD_ERASE_SECTOR: begin
                if (param_index != fesc_pkg::IDX_SECTOR || !addr_ok
                    || gaddr[2:0] != fesc_pkg::PHRASE_ZERO) begin
                  access_error_flag_nxt = 1'b1;
                end else if (sector_protected) begin
                  protect_violation_flag_nxt = 1'b1;
                end else begin
                  addr_nxt  = gaddr;
                  all_nxt   = 1'b0;
                  state_nxt = fesc_pkg::FESC_ERASE;
                end
              end
              fesc_pkg::CMD_UNSECURE: begin
                if (param_index != fesc_pkg::IDX_UNSECURE) begin
                  access_error_flag_nxt = 1'b1;
                end else if (any_protected) begin
                  protect_violation_flag_nxt = 1'b1;
                end else begin
                  all_nxt   = 1'b1;
                  state_nxt = fesc_pkg::FESC_ERASE;
                end
              end
              fesc_pkg::CMD_BACKDOOR_KEY: begin
                if (param_index != fesc_pkg::IDX_KEY
                    || backdoor_key_enable != fesc_pkg::KEY_ENABLED || key_lock_r) begin
                  access_error_flag_nxt = 1'b1;
                end else begin
                  state_nxt = fesc_pkg::FESC_COMPARE;
                end
              end
              fesc_pkg::CMD_USER_MARGIN: begin
                if (param_index != fesc_pkg::IDX_MARGIN || !addr_ok) begin
                  access_error_flag_nxt = 1'b1;
                end else begin
                  mblk_nxt = gaddr[23];
                  unique case (command_param_word_2)
                    fesc_pkg::MARGIN_NORMAL:  margin_nxt = fesc_pkg::LEVEL_NORMAL;
                    fesc_pkg::MARGIN_ERASED:  margin_nxt = fesc_pkg::LEVEL_ERASED;
                    fesc_pkg::MARGIN_PROGRAM: margin_nxt = fesc_pkg::LEVEL_PROGRAM;
                    default:                  access_error_flag_nxt = 1'b1;
                  endcase
                end
              end
              default: access_error_flag_nxt = 1'b1;
            endcase
          end
        end
      end
      fesc_pkg::FESC_ERASE: begin
        cnt_nxt = cnt_r + 1'b1;
        if (cnt_r == ERASE_CYCLES_P[fesc_pkg::CNT_W-1:0] - 1'b1) begin
          cnt_nxt   = '0;
          state_nxt = fesc_pkg::FESC_VERIFY;
        end
      end
      fesc_pkg::FESC_VERIFY: begin
        cnt_nxt = cnt_r + 1'b1;
        if (verify_error || verify_fatal) begin
          mg1_nxt = 1'b1;
        end
        if (verify_fatal) begin
          mg0_nxt = 1'b1;
        end
        if (cnt_r == fesc_pkg::CNT_W'(fesc_pkg::VERIFY_CYCLES - 1)) begin
          if (all_r && !mg1_nxt) begin
            release_nxt = 1'b1;
          end
          state_nxt = fesc_pkg::FESC_DONE;
        end
      end
      fesc_pkg::FESC_COMPARE: begin
        if (key_word != key_ref) begin
          access_error_flag_nxt   = 1'b1;
          key_lock_nxt = 1'b1;
          state_nxt    = fesc_pkg::FESC_DONE;
        end else if (key_i_r == 2'(fesc_pkg::NUM_KEYS - 1)) begin
          release_nxt = 1'b1;
          state_nxt   = fesc_pkg::FESC_DONE;
        end else begin
          key_i_nxt = key_i_r + 1'b1;
        end
      end
      fesc_pkg::FESC_DONE: begin
        command_complete_flag_nxt  = 1'b1;
        all_nxt   = 1'b0;
        state_nxt = fesc_pkg::FESC_IDLE;
      end
      default: state_nxt = fesc_pkg::FESC_IDLE;
    endcase
    // A new secure strap must not be masked by a stale release, so release clears while secured_in is low.
    if (!secured_in) begin
      release_nxt = 1'b0;
    end
    sec_act_nxt   = (state_nxt == fesc_pkg::FESC_ERASE) && !all_nxt;
    all_act_nxt   = (state_nxt == fesc_pkg::FESC_ERASE) && all_nxt;
    erase_len_nxt = (state_r == fesc_pkg::FESC_ERASE) ? erase_len_r + 1'b1 : '0;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_r    <= fesc_pkg::FESC_IDLE;
      command_complete_flag_r     <= 1'b1;
      access_error_flag_r   <= 1'b0;
      protect_violation_flag_r   <= 1'b0;
      mg1_r      <= 1'b0;
      mg0_r      <= 1'b0;
      release_r  <= 1'b0;
      key_lock_r <= 1'b0;
      all_r      <= 1'b0;
      addr_r     <= '0;
      margin_r   <= fesc_pkg::LEVEL_NORMAL;
      mblk_r     <= 1'b0;
      cnt_r      <= '0;
      key_i_r    <= 2'h0;
      sec_act_r  <= 1'b0;
      all_act_r  <= 1'b0;
      erase_len_r <= '0;
    end else begin
      state_r    <= state_nxt;
      command_complete_flag_r     <= command_complete_flag_nxt;
      access_error_flag_r   <= access_error_flag_nxt;
      protect_violation_flag_r   <= protect_violation_flag_nxt;
      mg1_r      <= mg1_nxt;
      mg0_r      <= mg0_nxt;
      release_r  <= release_nxt;
      key_lock_r <= key_lock_nxt;
      all_r      <= all_nxt;
      addr_r     <= addr_nxt;
      margin_r   <= margin_nxt;
      mblk_r     <= mblk_nxt;
      cnt_r      <= cnt_nxt;
      key_i_r    <= key_i_nxt;
      sec_act_r  <= sec_act_nxt;
      all_act_r  <= all_act_nxt;
      erase_len_r <= erase_len_nxt;
    end
  end

  assign command_complete_flag   = command_complete_flag_r;
  assign access_error_flag       = access_error_flag_r;
  assign protect_violation_flag  = protect_violation_flag_r;
  assign verify_error_flag       = mg1_r;
  assign verify_fatal_error_flag = mg0_r;
  assign secure_release          = release_r;
  assign erase_sector_act        = sec_act_r;
  assign erase_all_act           = all_act_r;
  assign erase_addr              = addr_r;
  assign margin_level            = margin_r;
  assign margin_block_eeprom     = mblk_r;

  // ==========================================================================
  // Checks
  // ==========================================================================
  chk_mode_access_error_flag: assert property (@(posedge core_clk) disable iff (sys_rst)
    (state_r == fesc_pkg::FESC_IDLE && launch && command_complete_flag_r && !access_error_flag_r && !protect_violation_flag_r && !cmd_permitted)
    |=> access_error_flag_r ##1 command_complete_flag_r)
    else $error("mode refusal did not flag access error");
  chk_sector_index: assert property (@(posedge core_clk) disable iff (sys_rst)
    (state_r == fesc_pkg::FESC_IDLE && launch && command_complete_flag_r && !access_error_flag_r && !protect_violation_flag_r
     && code == fesc_pkg::CMD_ERASE_SECTOR && param_index != fesc_pkg::IDX_SECTOR)
    |=> access_error_flag_r && state_r == fesc_pkg::FESC_DONE)
    else $error("bad sector index not refused");
  chk_sector_align: assert property (@(posedge core_clk) disable iff (sys_rst)
    (state_r == fesc_pkg::FESC_IDLE && launch && command_complete_flag_r && !access_error_flag_r && !protect_violation_flag_r && cmd_permitted
     && code == fesc_pkg::CMD_ERASE_SECTOR && gaddr[2:0] != fesc_pkg::PHRASE_ZERO)
    |=> access_error_flag_r && !erase_sector_act)
    else $error("misaligned sector address accepted");
  chk_protect_noerase: assert property (@(posedge core_clk) disable iff (sys_rst)
    $rose(protect_violation_flag_r) |-> state_r == fesc_pkg::FESC_DONE ##1 command_complete_flag_r && !erase_sector_act)
    else $error("protect violation did not skip erase");
  chk_erase_done: assert property (@(posedge core_clk) disable iff (sys_rst)
    (state_r == fesc_pkg::FESC_ERASE) |-> !command_complete_flag_r && erase_len_r < ERASE_CYCLES_P[fesc_pkg::CNT_W-1:0])
    else $error("erase phase overran its erase time");
  chk_release_clean: assert property (@(posedge core_clk) disable iff (sys_rst)
    ($rose(release_r) && all_r) |-> !mg1_r)
    else $error("security released after failed verify");
  chk_fatal_pair: assert property (@(posedge core_clk) disable iff (sys_rst)
    mg0_r |-> mg1_r)
    else $error("fatal verify flag without verify error");
  chk_key_lock: assert property (@(posedge core_clk) disable iff (sys_rst)
    (key_lock_r && state_r == fesc_pkg::FESC_IDLE && launch && command_complete_flag_r && !access_error_flag_r && !protect_violation_flag_r
     && code == fesc_pkg::CMD_BACKDOOR_KEY) |=> access_error_flag_r && $stable(release_r))
    else $error("locked key command ran");
  chk_margin_bad: assert property (@(posedge core_clk) disable iff (sys_rst)
    (state_r == fesc_pkg::FESC_IDLE && launch && command_complete_flag_r && !access_error_flag_r && !protect_violation_flag_r
     && code == fesc_pkg::CMD_USER_MARGIN && command_param_word_2 > fesc_pkg::MARGIN_PROGRAM)
    |=> access_error_flag_r && $stable(margin_r))
    else $error("invalid margin accepted");
endmodule // fesc_sequencer

/* File: fesc_host.sv */
// Host software model that loads command words and launches flash commands.
`timescale 1ns/1ps
module fesc_host (
  input  wire logic        core_clk,
  input  wire logic        command_complete_flag,
  output logic             launch,
  output logic [15:0]      command_param_word_0,
  output logic [15:0]      command_param_word_1,
  output logic [15:0]      command_param_word_2,
  output logic [15:0]      command_param_word_3,
  output logic [15:0]      command_param_word_4,
  output logic [2:0]       param_index,
  output logic             clear_errors
);
  // ==========================================================================
  // Command issue
  // ==========================================================================
  initial begin
    launch = 1'b0;
    clear_errors = 1'b0;
    {command_param_word_0, command_param_word_1, command_param_word_2} = 48'h0000_0000_0000;
    {command_param_word_3, command_param_word_4} = 32'h0000_0000;
    param_index = 3'h0;
  end
  task automatic issue(input logic [15:0] w0, w1, w2, w3, w4, input logic [2:0] idx);
    while (command_complete_flag !== 1'b1) @(posedge core_clk);
    @(posedge core_clk);
    #1;
    // word layout is chosen by the caller per command.
    {command_param_word_0, command_param_word_1, command_param_word_2} = {w0, w1, w2};
    {command_param_word_3, command_param_word_4} = {w3, w4};
    param_index = idx;
    launch = 1'b1;
    @(posedge core_clk);
    #1;
    launch = 1'b0;
  endtask
  // Access error and protect violation flags block every later launch, so software must clear them first.
  task automatic clear();
    @(posedge core_clk);
    #1;
    clear_errors = 1'b1;
    @(posedge core_clk);
    #1;
    clear_errors = 1'b0;
  endtask
endmodule // fesc_host

/* File: testbench.sv */
// Self-checking testbench of the flash command sequencer.
`timescale 1ns/1ps
module testbench;
  localparam int ERASE_P = 8;
  // The valid range is raised so that a margin target with address bit 23 set is reachable.
  localparam int TOP_P = 24'h80_0000;
  logic core_clk = 1'b0, sys_rst = 1'b1, launch, clear_errors, cmd_permitted = 1'b1;
  logic sector_protected = 1'b0, any_protected = 1'b0, secured_in = 1'b1;
  logic verify_error = 1'b0, verify_fatal = 1'b0, saw_sec = 1'b0, saw_all = 1'b0;
  logic [1:0] backdoor_key_enable = 2'h2;
  logic [63:0] stored_key = 64'h4444_3333_2222_1111;
  logic [15:0] w0, w1, w2, w3, w4;
  logic [2:0] param_index;
  logic command_complete_flag, access_error_flag, protect_violation_flag, verify_error_flag;
  logic verify_fatal_error_flag, secure_release, erase_sector_act, erase_all_act, margin_block_eeprom;
  logic [23:0] erase_addr;
  logic [1:0] margin_level;
  logic [3:0] flags;
  int mismatches = 0, total_checks = 0, cycles = 0;
  assign flags = {access_error_flag, protect_violation_flag, verify_error_flag, verify_fatal_error_flag};
  always #2.5 core_clk = ~core_clk;
  fesc_host fesc_host_inst (.core_clk(core_clk), .command_complete_flag(command_complete_flag),
    .launch(launch), .command_param_word_0(w0), .command_param_word_1(w1), .command_param_word_2(w2),
    .command_param_word_3(w3), .command_param_word_4(w4), .param_index(param_index),
    .clear_errors(clear_errors));
  fesc_sequencer #(.ERASE_CYCLES_P(ERASE_P), .FLASH_TOP_P(TOP_P)) fesc_sequencer_inst (.core_clk(core_clk),
    .sys_rst(sys_rst),
    .launch(launch), .command_param_word_0(w0), .command_param_word_1(w1), .command_param_word_2(w2),
    .command_param_word_3(w3), .command_param_word_4(w4), .param_index(param_index),
    .clear_errors(clear_errors), .cmd_permitted(cmd_permitted), .sector_protected(sector_protected),
    .any_protected(any_protected), .secured_in(secured_in), .backdoor_key_enable(backdoor_key_enable),
    .stored_key(stored_key), .verify_error(verify_error), .verify_fatal(verify_fatal),
    .command_complete_flag(command_complete_flag), .access_error_flag(access_error_flag),
    .protect_violation_flag(protect_violation_flag), .verify_error_flag(verify_error_flag),
    .verify_fatal_error_flag(verify_fatal_error_flag), .secure_release(secure_release),
    .erase_sector_act(erase_sector_act), .erase_all_act(erase_all_act), .erase_addr(erase_addr),
    .margin_level(margin_level), .margin_block_eeprom(margin_block_eeprom));
  // ==========================================================================
  // Helpers
  // ==========================================================================
  always @(posedge core_clk) begin
    if (erase_sector_act === 1'b1) saw_sec <= 1'b1;
    if (erase_all_act === 1'b1) saw_all <= 1'b1;
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      close_out();
    end
  end
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic do_reset();
    sys_rst = 1'b1;
    repeat (16) @(posedge core_clk);
    #1;
    sys_rst = 1'b0;
  endtask
  // Launches one command and returns the cycles until it completes.
  task automatic run(input logic [7:0] code, input logic [23:0] a, input logic [15:0] c2, c3, c4,
                     input logic [2:0] idx, output int n);
    saw_sec = 1'b0;
    saw_all = 1'b0;
    fesc_host_inst.issue({code, a[23:16]}, a[15:0], c2, c3, c4, idx);
    chk(24'(command_complete_flag), 24'h0);
    n = 0;
    while (command_complete_flag !== 1'b1 && n < 400) begin
      @(posedge core_clk);
      #1;
      n++;
    end
  endtask
  // Security release only drops while the device reads as unsecured.
  task automatic relock();
    secured_in = 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    secured_in = 1'b1;
  endtask
  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_erase();
    int n;
    run(fesc_pkg::CMD_ERASE_SECTOR, 24'h00_1008, 16'h0000, 16'h0000, 16'h0000, fesc_pkg::IDX_SECTOR, n);
    chk(24'(saw_sec), 24'h1);
    chk(erase_addr, 24'h00_1008);
    chk(24'(n > ERASE_P + 16), 24'h1);
    chk(24'(flags), 24'h0);
    verify_error = 1'b1;
    run(fesc_pkg::CMD_ERASE_SECTOR, 24'h00_1008, 16'h0000, 16'h0000, 16'h0000, fesc_pkg::IDX_SECTOR, n);
    chk(24'(flags), 24'h2);
    verify_fatal = 1'b1;
    run(fesc_pkg::CMD_ERASE_SECTOR, 24'h00_1008, 16'h0000, 16'h0000, 16'h0000, fesc_pkg::IDX_SECTOR, n);
    chk(24'(flags), 24'h3);
    {verify_error, verify_fatal} = 2'h0;
    $display("test erase done");
  endtask
  task automatic t_erase_bad();
    logic [2:0] ix [5] = '{3'h0, 3'h1, 3'h1, 3'h1, 3'h1};
    logic [23:0] ad [5] = '{24'h00_1000, 24'h80_0008, 24'h00_1004, 24'h00_1000, 24'h00_1000};
    logic [3:0] ef [5] = '{4'h8, 4'h8, 4'h8, 4'h8, 4'h4};
    int n;
    for (int i = 0; i < 5; i++) begin
      cmd_permitted = (i != 3);
      sector_protected = (i == 4);
      run(fesc_pkg::CMD_ERASE_SECTOR, ad[i], 16'h0000, 16'h0000, 16'h0000, ix[i], n);
      chk(24'(flags), 24'(ef[i]));
      chk(24'(saw_sec), 24'h0);
      chk(24'(n <= 3), 24'h1);
      fesc_host_inst.clear();
    end
    {cmd_permitted, sector_protected} = 2'h2;
    $display("test erase errors done");
  endtask
  task automatic t_unsecure();
    int n;
    verify_error = 1'b1;
    run(fesc_pkg::CMD_UNSECURE, 24'h00_0000, 16'h0000, 16'h0000, 16'h0000, fesc_pkg::IDX_UNSECURE, n);
    chk(24'(saw_all), 24'h1);
    chk(24'({flags, secure_release}), 24'h04);
    verify_error = 1'b0;
    run(fesc_pkg::CMD_UNSECURE, 24'h00_0000, 16'h0000, 16'h0000, 16'h0000, fesc_pkg::IDX_UNSECURE, n);
    chk(24'({flags, secure_release}), 24'h01);
    relock();
    any_protected = 1'b1;
    run(fesc_pkg::CMD_UNSECURE, 24'h00_0000, 16'h0000, 16'h0000, 16'h0000, fesc_pkg::IDX_UNSECURE, n);
    chk(24'({flags, saw_all, secure_release}), 24'h10);
    fesc_host_inst.clear();
    any_protected = 1'b0;
    run(fesc_pkg::CMD_UNSECURE, 24'h00_0000, 16'h0000, 16'h0000, 16'h0000, 3'h1, n);
    chk(24'({flags, saw_all}), 24'h10);
    fesc_host_inst.clear();
    $display("test unsecure done");
  endtask
  // Runs a key command with the last key word given; good keys end in 16'h4444.
  task automatic key(input logic [2:0] idx, input logic [15:0] k3, input logic [4:0] exp);
    int n;
    run(fesc_pkg::CMD_BACKDOOR_KEY, 24'h00_1111, 16'h2222, 16'h3333, k3, idx, n);
    chk(24'({flags, secure_release}), 24'(exp));
    fesc_host_inst.clear();
    relock();
  endtask
  task automatic t_key();
    backdoor_key_enable = 2'h1;
    key(fesc_pkg::IDX_KEY, 16'h4444, 5'h10);
    backdoor_key_enable = 2'h2;
    key(3'h3, 16'h4444, 5'h10);
    key(fesc_pkg::IDX_KEY, 16'h4444, 5'h01);
    key(fesc_pkg::IDX_KEY, 16'h4445, 5'h10);
    key(fesc_pkg::IDX_KEY, 16'h4444, 5'h10);
    do_reset();
    key(fesc_pkg::IDX_KEY, 16'h4444, 5'h01);
    $display("test key done");
  endtask
  task automatic t_margin();
    logic [1:0] lv [3] = '{fesc_pkg::LEVEL_NORMAL, fesc_pkg::LEVEL_ERASED, fesc_pkg::LEVEL_PROGRAM};
    int n;
    for (int m = 0; m < 4; m++) begin
      run(fesc_pkg::CMD_USER_MARGIN, 24'h00_0000, 16'(m), 16'h0000, 16'h0000, fesc_pkg::IDX_MARGIN, n);
      chk(24'({flags, margin_level, margin_block_eeprom}), (m < 3) ? 24'(lv[m] * 2) : 24'h44);
      fesc_host_inst.clear();
    end
    run(fesc_pkg::CMD_USER_MARGIN, 24'h00_0000, 16'h0001, 16'h0000, 16'h0000, 3'h1, n);
    chk(24'({flags, margin_level}), 24'h22);
    fesc_host_inst.clear();
    run(fesc_pkg::CMD_USER_MARGIN, 24'h80_0000, 16'h0001, 16'h0000, 16'h0000, fesc_pkg::IDX_MARGIN, n);
    chk(24'({flags, margin_level, margin_block_eeprom}), 24'h03);
    $display("test margin done");
  endtask
  initial begin
    do_reset();
    t_erase();
    t_erase_bad();
    t_unsecure();
    t_key();
    t_margin();
    close_out();
  end
endmodule // testbench
